// ---- bench/virtual_link_state_transitions_test.sv ----
// self-checking bench for the virtual link state machine
`include "vls_regs.svh"
module virtual_link_state_transitions_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                ref_clk_in, rst_in, upstream_in, slow, send_req;
  logic                ll_req_l1_in, ll_req_l2_in, ll_req_active_in;
  logic                active_xchg_done_in;
  logic [2:0]          req_state;
  logic [15:0]         lfsr_q;
  logic [15:0]         cue;
  logic [9:0]          exp_q;
  vls_pkg::vls_phy_t   phy_in;
  vls_pkg::vls_msg_t   rx_msg, tx_msg;
  vls_pkg::vls_state_t state;
  int                  mismatches, n_compared;

  vls_fsm uut (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
    .upstream_in(upstream_in), .ll_req_l1_in(ll_req_l1_in),
    .ll_req_l2_in(ll_req_l2_in), .ll_req_active_in(ll_req_active_in),
    .rx_msg_in(rx_msg), .phy_in(phy_in),
    .active_xchg_done_in(active_xchg_done_in), .state_out(state),
    .tx_msg_out(tx_msg));
  vls_remote_model remote (.clk_in(ref_clk_in), .rst_in(rst_in),
    .slow_in(slow), .send_req_in(send_req), .req_state_in(req_state),
    .tx_msg_in(tx_msg), .rx_msg_out(rx_msg));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic is_rx(input logic [1:0] k, input logic [2:0] s);
    return rx_msg.kind == k && rx_msg.state == s;
  endfunction
  // next expected {state, message kind, message state, request out,
  // non-active exit seen}, from the inputs sampled at this edge
  function automatic logic [9:0] exp_step(input logic [9:0] c);
    logic [2:0] s;
    logic [4:0] m;
    logic       sent;
    logic       nx;
    logic       ex;
    s    = c[9:7];
    m    = 5'h00;
    sent = c[1];
    nx   = c[0];
    ex   = phy_in.rec_exit_l0;
    if (s == `VLS_ST_ACTIVE) begin
      if (phy_in.rec_enter || (upstream_in && ex &&
          phy_in.sync_result == `VLS_ST_RETRAIN)) begin
        s    = `VLS_ST_RETRAIN;
        sent = 1'b0;
      end else if (upstream_in) begin
        if (sent && is_rx(`VLS_MSG_STS, `VLS_ST_L1)) begin
          s    = `VLS_ST_L1;
          sent = 1'b0;
        end else if (sent && is_rx(`VLS_MSG_STS, `VLS_ST_L2)) begin
          s    = `VLS_ST_L2;
          sent = 1'b0;
        end else if (!sent && (ll_req_l1_in || ll_req_l2_in)) begin
          m    = {`VLS_MSG_REQ, ll_req_l1_in ? `VLS_ST_L1 : `VLS_ST_L2};
          sent = 1'b1;
        end
      end else if (ll_req_l1_in && is_rx(`VLS_MSG_REQ, `VLS_ST_L1)) begin
        s = `VLS_ST_L1;
        m = {`VLS_MSG_STS, `VLS_ST_L1};
      end else if (ll_req_l2_in && is_rx(`VLS_MSG_REQ, `VLS_ST_L2)) begin
        s = `VLS_ST_L2;
        m = {`VLS_MSG_STS, `VLS_ST_L2};
      end
    end else if (s == `VLS_ST_L1) begin
      if (is_rx(`VLS_MSG_REQ, `VLS_ST_ACTIVE)) begin
        s = `VLS_ST_RETRAIN;
      end
    end else if (s == `VLS_ST_RETRAIN) begin
      nx = c[0] || (ex && phy_in.sync_result != `VLS_ST_ACTIVE);
      if (upstream_in && ex && phy_in.sync_result == `VLS_ST_RESET) begin
        s  = `VLS_ST_RESET;
        nx = 1'b0;
      end else if (ll_req_active_in &&
                   ((ex && phy_in.sync_result == `VLS_ST_ACTIVE) ||
                    (active_xchg_done_in && (c[0] || phy_in.in_l0)))) begin
        s  = `VLS_ST_ACTIVE;
        nx = 1'b0;
      end
    end
    return {s, m, sent, nx};
  endfunction
  task automatic compare(input string what, input logic [7:0] exp,
                         input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic check_cycle();
    @(negedge ref_clk_in);
    compare("state_out", {5'h00, exp_q[9:7]},
            {5'h00, state});
    compare("tx_msg_out", {3'h0, exp_q[6:2]},
            {3'h0, tx_msg});
  endtask
  task automatic drive(input logic [15:0] r, input logic [2:0] sync);
    @(posedge ref_clk_in);
    ll_req_l1_in        <= r[0];
    ll_req_l2_in        <= r[1];
    ll_req_active_in    <= r[2];
    active_xchg_done_in <= r[3];
    slow                <= r[4];
    send_req            <= r[5];
    req_state           <= {1'h0, r[7:6]};
    // recovery events kept rare so that the power states get reached
    phy_in              <= '{rec_enter: &r[11:8], rec_exit_l0: &r[13:12],
                             in_l0: r[14], sync_result: sync};
  endtask
  task automatic restart(input logic up);
    drive(16'h0000, 3'h0);
    rst_in      <= 1'b1;
    upstream_in <= up;
    repeat (8) check_cycle();
    @(posedge ref_clk_in);
    rst_in <= 1'b0;
  endtask
  // reference machine: reset parks it in Retrain like the design
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      exp_q <= {`VLS_ST_RETRAIN, 7'h00};
    end else begin
      exp_q <= exp_step(exp_q);
    end
  end
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    // about 1100 cycles are needed; the rest is margin
    repeat (3000) @(posedge ref_clk_in);
    mismatches++;
    give_verdict();
  end
  initial begin
    {rst_in, upstream_in, slow, send_req} = 4'hA;
    {ll_req_l1_in, ll_req_l2_in, ll_req_active_in} = 3'h0;
    active_xchg_done_in = 1'b0;
    req_state = 3'h0;
    phy_in = '0;
    lfsr_q = 16'h63B0;
    cue = 16'h0000;
    for (int pass = 0; pass < 6; pass++) begin
      restart(pass[0]);
      // corner: wake from Retrain, enter L1, then the remote wakes it
      for (int i = 0; i < 8; i++) begin
        cue = (i == 0) ? 16'h400C : (i < 5) ? 16'h0061 : 16'h0020;
        drive(cue, 3'h0);
        check_cycle();
      end
      for (int i = 0; i < 150; i++) begin
        lfsr_q = lfsr_next(lfsr_q);
        drive(lfsr_q, lfsr_q[15:13] % 3'h5);
        check_cycle();
      end
      restart(pass[0]);
      // corner: every sync result on a Recovery exit to L0
      for (int s = 0; s < 5; s++) begin
        drive(16'h700C, s[2:0]);
        check_cycle();
      end
    end
    give_verdict();
  end
endmodule // virtual_link_state_transitions_test

// ---- bench/vls_remote_model.sv ----
// remote arbiter mux state machine facing this port across the link
`include "vls_regs.svh"
module vls_remote_model (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              slow_in,
  input  wire logic              send_req_in,
  input  wire logic [2:0]        req_state_in,
  input  wire vls_pkg::vls_msg_t tx_msg_in,
  output vls_pkg::vls_msg_t      rx_msg_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       pend_q;
  logic [2:0] pend_state_q;
  logic [1:0] wait_q;
  // ----------------------------------------------------------------
  // answer each request with a status naming the same state
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pend_q       <= 1'h0;
      pend_state_q <= 3'h0;
      wait_q       <= 2'h0;
      rx_msg_out   <= '0;
    end else begin
      rx_msg_out <= '0;
      if (tx_msg_in.kind == `VLS_MSG_REQ) begin
        pend_q       <= 1'h1;
        pend_state_q <= tx_msg_in.state;
        // slow mode lets the request sit a few cycles unanswered
        wait_q       <= slow_in ? 2'h3 : 2'h0;
      end else if (pend_q && wait_q == 2'h0) begin
        rx_msg_out <= '{kind: `VLS_MSG_STS, state: pend_state_q};
        pend_q     <= 1'h0;
      end else if (pend_q) begin
        wait_q <= wait_q - 2'h1;
      end else if (send_req_in) begin
        rx_msg_out <= '{kind: `VLS_MSG_REQ, state: req_state_in};
      end
    end
  end
endmodule // vls_remote_model

// ---- rtl/vls_fsm.sv ----
// virtual link state machine of one protocol behind the link arbiter mux
`include "vls_regs.svh"
module vls_fsm (
  input  wire logic              ref_clk_in,
  input  wire logic              rst_in,
  input  wire logic              upstream_in,
  input  wire logic              ll_req_l1_in,
  input  wire logic              ll_req_l2_in,
  input  wire logic              ll_req_active_in,
  input  wire vls_pkg::vls_msg_t rx_msg_in,
  input  wire vls_pkg::vls_phy_t phy_in,
  input  wire logic              active_xchg_done_in,
  output vls_pkg::vls_state_t    state_out,
  output vls_pkg::vls_msg_t      tx_msg_out
);

  // -------------------------------------------------------------------
  // message and phy decode
  // -------------------------------------------------------------------
  function automatic logic is_msg(input vls_pkg::vls_msg_t m,
                                  input logic [1:0] k,
                                  input logic [2:0] s);
    is_msg = (m.kind == k) && (m.state == s);
  endfunction

  vls_pkg::vls_state_t state_q;
  vls_pkg::vls_state_t state_d;
  vls_pkg::vls_msg_t   tx_q;
  vls_pkg::vls_msg_t   tx_d;
  logic                req_sent_q;
  logic                req_sent_d;
  logic                nonact_exit_q;
  logic                nonact_exit_d;

  wire rx_req_l1  = is_msg(rx_msg_in, `VLS_MSG_REQ, `VLS_ST_L1);
  wire rx_req_l2  = is_msg(rx_msg_in, `VLS_MSG_REQ, `VLS_ST_L2);
  wire rx_sts_l1  = is_msg(rx_msg_in, `VLS_MSG_STS, `VLS_ST_L1);
  wire rx_sts_l2  = is_msg(rx_msg_in, `VLS_MSG_STS, `VLS_ST_L2);
  wire rx_req_act = is_msg(rx_msg_in, `VLS_MSG_REQ, `VLS_ST_ACTIVE);
  wire exit_act   = phy_in.rec_exit_l0 &&
                    (phy_in.sync_result == `VLS_ST_ACTIVE);
  wire exit_rtr   = phy_in.rec_exit_l0 &&
                    (phy_in.sync_result == `VLS_ST_RETRAIN);
  wire exit_rst   = phy_in.rec_exit_l0 &&
                    (phy_in.sync_result == `VLS_ST_RESET);
  wire exit_other = phy_in.rec_exit_l0 && !exit_act;

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    state_d       = state_q;          // R13
    tx_d          = '0;               // R13
    req_sent_d    = req_sent_q;
    nonact_exit_d = nonact_exit_q;
    unique case (state_q)
      vls_pkg::VLS_ACTIVE: begin
        // recovery entry wins over any power handshake in flight
        if (phy_in.rec_enter) begin
          state_d    = vls_pkg::VLS_RETRAIN;               // R6
          req_sent_d = 1'b0;
        end else if (upstream_in && exit_rtr) begin
          state_d    = vls_pkg::VLS_RETRAIN;               // R7
          req_sent_d = 1'b0;
        end else if (upstream_in) begin
          // a reset resolution here is ignored: no direct path // R12
          if (req_sent_q && rx_sts_l1) begin
            state_d    = vls_pkg::VLS_L1;                  // R1
            req_sent_d = 1'b0;
          end else if (req_sent_q && rx_sts_l2) begin
            state_d    = vls_pkg::VLS_L2;                  // R3
            req_sent_d = 1'b0;
          end else if (!req_sent_q && ll_req_l1_in) begin
            tx_d       = '{`VLS_MSG_REQ, `VLS_ST_L1};      // R1
            req_sent_d = 1'b1;
          end else if (!req_sent_q && ll_req_l2_in) begin
            tx_d       = '{`VLS_MSG_REQ, `VLS_ST_L2};      // R3
            req_sent_d = 1'b1;
          end
        end else begin
          if (ll_req_l1_in && rx_req_l1) begin
            tx_d    = '{`VLS_MSG_STS, `VLS_ST_L1};         // R2
            state_d = vls_pkg::VLS_L1;
          end else if (ll_req_l2_in && rx_req_l2) begin
            tx_d    = '{`VLS_MSG_STS, `VLS_ST_L2};         // R4
            state_d = vls_pkg::VLS_L2;
          end
        end
      end
      vls_pkg::VLS_L1: begin
        if (rx_req_act) begin
          state_d = vls_pkg::VLS_RETRAIN;                  // R5
        end
      end
      vls_pkg::VLS_L2: begin
        state_d = state_q;
      end
      vls_pkg::VLS_RETRAIN: begin
        if (exit_other) begin
          nonact_exit_d = 1'b1;
        end
        if (upstream_in && exit_rst) begin
          state_d       = vls_pkg::VLS_RESET;              // R11
          nonact_exit_d = 1'b0;
        end else if (ll_req_active_in && exit_act) begin
          state_d       = vls_pkg::VLS_ACTIVE;             // R8
          nonact_exit_d = 1'b0;
        end else if (ll_req_active_in && active_xchg_done_in &&
                     (nonact_exit_q || phy_in.in_l0)) begin
          state_d       = vls_pkg::VLS_ACTIVE;             // R9 R10
          nonact_exit_d = 1'b0;
        end
      end
      vls_pkg::VLS_RESET: begin
        state_d = state_q;
      end
    endcase
  end

  // -------------------------------------------------------------------
  // state registers
  // -------------------------------------------------------------------
  // reset parks in Retrain so bring-up leaves through the Active rules;
  // Reset stays a sink that only the wider link bring-up can clear
  always_ff @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q       <= vls_pkg::VLS_RETRAIN;
      tx_q          <= '0;
      req_sent_q    <= 1'b0;
      nonact_exit_q <= 1'b0;
    end else begin
      state_q       <= state_d;
      tx_q          <= tx_d;
      req_sent_q    <= req_sent_d;
      nonact_exit_q <= nonact_exit_d;
    end
  end

  assign state_out  = state_q;
  assign tx_msg_out = tx_q;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  property p_no_act_to_reset;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_ACTIVE |=> state_q != vls_pkg::VLS_RESET;
  endproperty
  a_no_act_to_reset: assert property (p_no_act_to_reset) // R12
    else $error("active went straight to reset");

  property p_rec_retrain;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_ACTIVE && phy_in.rec_enter
      |=> state_q == vls_pkg::VLS_RETRAIN;
  endproperty
  a_rec_retrain: assert property (p_rec_retrain) // R6
    else $error("recovery did not force retrain");

  property p_l1_wake;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_L1 && rx_req_act
      |=> state_q == vls_pkg::VLS_RETRAIN;
  endproperty
  a_l1_wake: assert property (p_l1_wake) // R5
    else $error("l1 ignored active request");

  property p_up_l1_needs_sts;
    @(posedge ref_clk_in) disable iff (rst_in)
      upstream_in && state_q == vls_pkg::VLS_ACTIVE
      && !(rx_sts_l1 && req_sent_q) |=> state_q != vls_pkg::VLS_L1;
  endproperty
  a_up_l1_needs_sts: assert property (p_up_l1_needs_sts) // R1
    else $error("upstream entered l1 without status");

  property p_dn_sts_l1;
    @(posedge ref_clk_in) disable iff (rst_in)
      !upstream_in && !(ll_req_l1_in && rx_req_l1)
      |=> !(tx_q.kind == `VLS_MSG_STS && tx_q.state == `VLS_ST_L1);
  endproperty
  a_dn_sts_l1: assert property (p_dn_sts_l1) // R2
    else $error("downstream l1 status without both requests");

  property p_dn_sts_l2;
    @(posedge ref_clk_in) disable iff (rst_in)
      !upstream_in && !(ll_req_l2_in && rx_req_l2)
      |=> !(tx_q.kind == `VLS_MSG_STS && tx_q.state == `VLS_ST_L2);
  endproperty
  a_dn_sts_l2: assert property (p_dn_sts_l2) // R4
    else $error("downstream l2 status without both requests");

  property p_up_l2_needs_sts;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_ACTIVE ##1 state_q == vls_pkg::VLS_L2
      |-> $past(rx_sts_l2) || !$past(upstream_in);
  endproperty
  a_up_l2_needs_sts: assert property (p_up_l2_needs_sts) // R3
    else $error("upstream entered l2 without status");

  property p_dn_no_reset;
    @(posedge ref_clk_in) disable iff (rst_in)
      !upstream_in && state_q == vls_pkg::VLS_RETRAIN
      |=> state_q != vls_pkg::VLS_RESET;
  endproperty
  a_dn_no_reset: assert property (p_dn_no_reset) // R11
    else $error("downstream reached reset from retrain");

  property p_retrain_exit_act;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_RETRAIN && ll_req_active_in && exit_act
      && !(upstream_in && exit_rst) |=> state_q == vls_pkg::VLS_ACTIVE;
  endproperty
  a_retrain_exit_act: assert property (p_retrain_exit_act) // R8
    else $error("retrain did not return to active");

  property p_up_exit_retrain;
    @(posedge ref_clk_in) disable iff (rst_in)
      upstream_in && state_q == vls_pkg::VLS_ACTIVE && exit_rtr
      |=> state_q == vls_pkg::VLS_RETRAIN;
  endproperty
  a_up_exit_retrain: assert property (p_up_exit_retrain) // R7
    else $error("upstream ignored a retrain resolution");

  property p_retrain_in_l0;
    @(posedge ref_clk_in) disable iff (rst_in)
      state_q == vls_pkg::VLS_RETRAIN && ll_req_active_in
      && active_xchg_done_in && phy_in.in_l0
      && !(upstream_in && exit_rst) |=> state_q == vls_pkg::VLS_ACTIVE;
  endproperty
  a_retrain_in_l0: assert property (p_retrain_in_l0) // R10
    else $error("retrain in l0 did not return to active");

endmodule // vls_fsm

// ---- rtl/vls_pkg.sv ----
// types shared by the virtual link state machine
package vls_pkg;
  typedef enum logic [2:0] {
    VLS_ACTIVE,
    VLS_L1,
    VLS_L2,
    VLS_RETRAIN,
    VLS_RESET
  } vls_state_t;

  typedef struct packed {
    logic [1:0] kind;
    logic [2:0] state;
  } vls_msg_t;

  typedef struct packed {
    logic       rec_enter;
    logic       rec_exit_l0;
    logic       in_l0;
    logic [2:0] sync_result;
  } vls_phy_t;
endpackage : vls_pkg

// ---- rtl/vls_regs.svh ----
// timing-free constants and encodings for the virtual link state machine
// Summary of operation
// R1: an upstream port in Active with a link-layer L1.x request sends a request message for L1.x and enters L1.x only on a returned L1.x status message.
// R2: a downstream port in Active sends an L1.x status message only when its link layer requests L1.x and a remote L1.x request message has arrived.
// R3: an upstream port in Active with a link-layer L2 request sends a request message for L2 and enters L2 only on a returned L2 status message.
// R4: a downstream port in Active sends an L2 status message only when its link layer requests L2 and a remote L2 request message has arrived.
// R5: in L1 either port type moves to Retrain on a remote Active request message.
// R6: in Active either port type moves to Retrain when the phy training state machine enters Recovery.
// R7: an upstream port in Active also moves to Retrain when the phy returns from Recovery to L0 and exit synchronization resolves to Retrain.
// R8: in Retrain with Active requested, the port moves to Active when the phy leaves Recovery for L0 and exit synchronization resolves to Active.
// R9: in Retrain with Active requested, the port also moves to Active after Recovery exit that did not resolve to Active once the Active message exchange completes.
// R10: in Retrain with Active requested, the port moves to Active when the phy is already in L0 and the Active message exchange completes.
// R11: an upstream port in Retrain moves to Reset when the phy reaches L0 and exit synchronization resolves to Reset; a downstream port never does.
// R12: the machine never goes straight from Active to Reset; Reset is reached only through Retrain.
// R13: with no trigger the machine holds its state and sends no new message.
`ifndef VLS_REGS_SVH
`define VLS_REGS_SVH
// message kind encodings
`define VLS_MSG_NONE    2'h0
`define VLS_MSG_REQ     2'h1
`define VLS_MSG_STS     2'h2
// named link states carried in messages and in the sync result
`define VLS_ST_ACTIVE   3'h0
`define VLS_ST_L1       3'h1
`define VLS_ST_L2       3'h2
`define VLS_ST_RETRAIN  3'h3
`define VLS_ST_RESET    3'h4
`endif
